/* File: core/rcc_pkg.sv */
// Purpose: Constants and types of the reset cause collector.
// Assumes: 125 MHz system clock, 32-bit AXI4-Lite register port.
// Notes:
// Notes on behaviour
// - All reset requests merge into one master reset
// - Primary configuration read error sets bit 27
// - Primary and alternate read error sets bit 26
// - Configuration mismatch reset sets bit 9
// - Master-clear pin reset sets bit 7
// - Executed software reset sets bit 6
// - Deadman timer time-out sets bit 5
// - Watchdog timer time-out sets bit 4
// - Wake from sleep sets bit 3
// - Wake from idle sets bit 2
// - Brown-out sets bit 1, one after power-up
// - Power-on sets bit 0, one after power-up

package rcc_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] RCC_STATUS_OFF = 8'h00;
   localparam logic [7:0] RCC_IRQ_STAT_OFF = 8'h04;
   localparam logic [7:0] RCC_IRQ_CLR_OFF = 8'h08;
   localparam logic [7:0] RCC_IRQ_EN_OFF = 8'h0c;
   localparam logic [7:0] RCC_SW_RST_OFF = 8'h10;

   // ---------------------------------------------------------------
   // Status fields
   // ---------------------------------------------------------------
   localparam int RCC_B_PRI_CFG_ERR = 27;
   localparam int RCC_B_BOTH_CFG_ERR = 26;
   localparam int RCC_B_CFG_MISMATCH = 9;
   localparam int RCC_B_EXT_PIN = 7;
   localparam int RCC_B_SOFTWARE = 6;
   localparam int RCC_B_DEADMAN = 5;
   localparam int RCC_B_WATCHDOG = 4;
   localparam int RCC_B_SLEEP = 3;
   localparam int RCC_B_IDLE = 2;
   localparam int RCC_B_BROWNOUT = 1;
   localparam int RCC_B_POWERON = 0;
   localparam int RCC_B_SW_RST_GO = 0;

   localparam logic [31:0] RCC_STATUS_MASK = 32'h0c0002ff;
   localparam logic [31:0] RCC_STATUS_RST = 32'h00000003;
   localparam logic [31:0] RCC_ZERO_RST = 32'h00000000;

   // ---------------------------------------------------------------
   // Bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0] RCC_RESP_OKAY = 2'b00;
   localparam logic [1:0] RCC_RESP_SLVERR = 2'b10;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int RCC_CLK_MHZ = 125;
   localparam int RCC_RST_HOLD_NS = 1000;
   localparam int RCC_RST_HOLD_CYC = (RCC_RST_HOLD_NS * RCC_CLK_MHZ + 999) / 1000;
   localparam int RCC_CNT_W = 8;

   typedef enum logic [2:0] {
      RCC_ST_IDLE = 3'b001,
      RCC_ST_ASSERT = 3'b010,
      RCC_ST_HOLD = 3'b100
   } rcc_state_t;

endpackage

/* File: core/rcc_axil_slave.sv */
// Purpose: AXI4-Lite slave front end, one write and one read at a time.
// Assumes: Register decode and data come from the parent.
// Notes: Write address and data are taken in either order.
`timescale 1ns/1ps
`default_nettype none

module rcc_axil_slave
   import rcc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);

   logic aw_held_reg;
   logic w_held_reg;

   assign awready = ~aw_held_reg;
   assign wready = ~w_held_reg;
   assign arready = ~rvalid;
   assign wr_en = aw_held_reg & w_held_reg & ~bvalid;
   assign rd_addr = araddr;

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         wr_addr <= '0;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RCC_RESP_OKAY;
      end else begin
         if (awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_en) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok ? RCC_RESP_OKAY : RCC_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RCC_RESP_OKAY;
      end else if (arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rdata <= rd_ok ? rd_data : 32'h00000000;
         rresp <= rd_ok ? RCC_RESP_OKAY : RCC_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* File: core/rcc_top.sv */
// Purpose: Reset cause collector; merges reset requests into one master
//          reset and records the cause in a status register.
// Assumes: All request inputs are synchronous to CLK and active high,
//          except the master-clear pin which is active low.
// Notes: The status register is reset only by NRST, so the cause
//        survives the master reset that it describes.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rcc_top
   import rcc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int RST_HOLD_CYC = RCC_RST_HOLD_CYC
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic POWER_ON_REQUEST,
   input wire logic BROWNOUT_REQUEST,
   input wire logic MASTER_CLEAR_PIN_N,
   input wire logic WATCHDOG_RESET_REQUEST,
   input wire logic DEADMAN_RESET_REQUEST,
   input wire logic CONFIG_MISMATCH_REQUEST,
   input wire logic PRIMARY_CONFIG_READ_ERROR,
   input wire logic BOTH_CONFIG_READ_ERROR,
   input wire logic SLEEP_WAKE,
   input wire logic IDLE_WAKE,
   output logic SYSTEM_MASTER_RESET,
   output logic IRQ
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   logic [31:0] wmask;
   logic [7:0] wr_word;
   logic [7:0] rd_word;

   logic [31:0] status_reg;
   logic [31:0] irq_stat_reg;
   logic [31:0] irq_en_reg;
   logic [31:0] set_vec;
   logic sw_req_reg;
   logic any_req;
   logic status_wr;
   logic irq_clr_wr;

   rcc_state_t state_reg;
   rcc_state_t state_next;
   logic [RCC_CNT_W-1:0] cnt_reg;
   logic [RCC_CNT_W-1:0] cnt_next;
   logic sys_rst_reg;
   logic irq_reg;

   localparam logic [RCC_CNT_W-1:0] HOLD_LAST = RCC_CNT_W'(RST_HOLD_CYC - 1);

   // ---------------------------------------------------------------
   // Bus front end
   // ---------------------------------------------------------------
   rcc_axil_slave #(
      .ADDR_W(ADDR_W)
   ) u_bus (
      .clk(CLK),
      .nrst(NRST),
      .awaddr(S_AXI_AWADDR),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .bresp(S_AXI_BRESP),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .araddr(S_AXI_ARADDR),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // Word-aligned addresses; low address bits are ignored
   assign wr_word = {wr_addr[7:2], 2'b00};
   assign rd_word = {rd_addr[7:2], 2'b00};
   assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   always_comb begin
      wr_ok = 1'b1;
      case (wr_word)
         RCC_STATUS_OFF, RCC_IRQ_STAT_OFF, RCC_IRQ_CLR_OFF,
         RCC_IRQ_EN_OFF, RCC_SW_RST_OFF: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_comb begin
      rd_ok = 1'b1;
      rd_data = 32'h00000000;
      case (rd_word)
         RCC_STATUS_OFF: rd_data = status_reg;
         RCC_IRQ_STAT_OFF: rd_data = irq_stat_reg;
         RCC_IRQ_EN_OFF: rd_data = irq_en_reg;
         RCC_IRQ_CLR_OFF, RCC_SW_RST_OFF: rd_data = 32'h00000000;
         default: rd_ok = 1'b0;
      endcase
   end

   assign status_wr = wr_en && (wr_word == RCC_STATUS_OFF);
   assign irq_clr_wr = wr_en && (wr_word == RCC_IRQ_CLR_OFF);

   // ---------------------------------------------------------------
   // Software reset request
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         sw_req_reg <= 1'b0;
      end else begin
         sw_req_reg <= wr_en && (wr_word == RCC_SW_RST_OFF) && wr_strb[0]
            && wr_data[RCC_B_SW_RST_GO];
      end
   end

   // ---------------------------------------------------------------
   // Cause events
   // ---------------------------------------------------------------
   always_comb begin
      set_vec = 32'h00000000;
      set_vec[RCC_B_PRI_CFG_ERR] = PRIMARY_CONFIG_READ_ERROR;
      set_vec[RCC_B_BOTH_CFG_ERR] = BOTH_CONFIG_READ_ERROR;
      set_vec[RCC_B_CFG_MISMATCH] = CONFIG_MISMATCH_REQUEST;
      set_vec[RCC_B_EXT_PIN] = ~MASTER_CLEAR_PIN_N;
      set_vec[RCC_B_SOFTWARE] = sw_req_reg;
      set_vec[RCC_B_DEADMAN] = DEADMAN_RESET_REQUEST;
      set_vec[RCC_B_WATCHDOG] = WATCHDOG_RESET_REQUEST;
      set_vec[RCC_B_SLEEP] = SLEEP_WAKE;
      set_vec[RCC_B_IDLE] = IDLE_WAKE;
      set_vec[RCC_B_BROWNOUT] = BROWNOUT_REQUEST;
      set_vec[RCC_B_POWERON] = POWER_ON_REQUEST;
   end

   // ---------------------------------------------------------------
   // Status and interrupt bits
   // ---------------------------------------------------------------
   // Hardware set wins over a software write in the same cycle
   for (genvar i = 0; i < 32; i++) begin : g_bit
      if (RCC_STATUS_MASK[i]) begin : g_impl
         always_ff @(posedge CLK) begin
            if (!NRST) begin
               status_reg[i] <= RCC_STATUS_RST[i];
            end else if (set_vec[i]) begin
               status_reg[i] <= 1'b1;
            end else if (status_wr && wmask[i]) begin
               status_reg[i] <= wr_data[i];
            end
         end

         always_ff @(posedge CLK) begin
            if (!NRST) begin
               irq_stat_reg[i] <= RCC_ZERO_RST[i];
            end else if (set_vec[i]) begin
               irq_stat_reg[i] <= 1'b1;
            end else if (irq_clr_wr && wmask[i] && wr_data[i]) begin
               irq_stat_reg[i] <= 1'b0;
            end
         end

         always_ff @(posedge CLK) begin
            if (!NRST) begin
               irq_en_reg[i] <= RCC_ZERO_RST[i];
            end else if (wr_en && (wr_word == RCC_IRQ_EN_OFF) && wmask[i]) begin
               irq_en_reg[i] <= wr_data[i];
            end
         end
      end else begin : g_unused
         assign status_reg[i] = 1'b0;
         assign irq_stat_reg[i] = 1'b0;
         assign irq_en_reg[i] = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_reg & irq_en_reg);
      end
   end

   // ---------------------------------------------------------------
   // Master reset sequencer
   // ---------------------------------------------------------------
   assign any_req = POWER_ON_REQUEST | BROWNOUT_REQUEST | ~MASTER_CLEAR_PIN_N
      | sw_req_reg | WATCHDOG_RESET_REQUEST | DEADMAN_RESET_REQUEST
      | CONFIG_MISMATCH_REQUEST;

   // Reset is held while any request stands, then stretched
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         RCC_ST_IDLE: begin
            if (any_req) begin
               state_next = RCC_ST_ASSERT;
            end
         end
         RCC_ST_ASSERT: begin
            if (!any_req) begin
               state_next = RCC_ST_HOLD;
               cnt_next = HOLD_LAST;
            end
         end
         RCC_ST_HOLD: begin
            if (any_req) begin
               state_next = RCC_ST_ASSERT;
            end else if (cnt_reg == '0) begin
               state_next = RCC_ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: begin
            state_next = RCC_ST_HOLD;
            cnt_next = HOLD_LAST;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         state_reg <= RCC_ST_HOLD;
         cnt_reg <= HOLD_LAST;
         sys_rst_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sys_rst_reg <= (state_next != RCC_ST_IDLE);
      end
   end

   assign SYSTEM_MASTER_RESET = sys_rst_reg;
   assign IRQ = irq_reg;

endmodule

`default_nettype wire

/* File: verif/rcc_monitor.sv */
// Purpose: Master reset and register bus checks for the reset cause collector.
// Assumes: Sees only the top ports; one clock domain.
// Notes: The release check allows slack past the hold count.
`timescale 1ns/1ps
`default_nettype none
module rcc_monitor
   import rcc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int RST_HOLD_CYC = RCC_RST_HOLD_CYC
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic POWER_ON_REQUEST,
   input wire logic BROWNOUT_REQUEST,
   input wire logic MASTER_CLEAR_PIN_N,
   input wire logic WATCHDOG_RESET_REQUEST,
   input wire logic DEADMAN_RESET_REQUEST,
   input wire logic CONFIG_MISMATCH_REQUEST,
   input wire logic SYSTEM_MASTER_RESET
);
   logic [7:0] quiet_reg, wr_quiet_reg;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic any_req;
   assign any_req = POWER_ON_REQUEST | BROWNOUT_REQUEST | ~MASTER_CLEAR_PIN_N | WATCHDOG_RESET_REQUEST |
      DEADMAN_RESET_REQUEST | CONFIG_MISMATCH_REQUEST;
   // Cycles since the last request, and since the last write answer
   always_ff @(posedge CLK) begin
      if (!NRST || any_req) quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hff) quiet_reg <= quiet_reg + 8'h01;
   end
   always_ff @(posedge CLK) begin
      if (!NRST || (S_AXI_BVALID && S_AXI_BREADY)) wr_quiet_reg <= 8'h00;
      else if (wr_quiet_reg != 8'hff) wr_quiet_reg <= wr_quiet_reg + 8'h01;
   end
   always_ff @(posedge CLK) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) rd_addr_reg <= S_AXI_ARADDR;
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   req_to_reset_a: assert property (any_req |=> SYSTEM_MASTER_RESET)
      else $error("master reset missed a request");
   reset_hold_a: assert property (quiet_reg < RST_HOLD_CYC |-> SYSTEM_MASTER_RESET)
      else $error("master reset released too early");
   reset_release_a: assert property (quiet_reg > RST_HOLD_CYC + 2 && wr_quiet_reg > RST_HOLD_CYC + 3
      |-> !SYSTEM_MASTER_RESET) else $error("master reset held too long");
   read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address taken while answer pending");
   read_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)
      && $stable(S_AXI_RRESP)) else $error("read answer changed before taken");
   write_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write answer changed before taken");
   unused_zero_a: assert property (S_AXI_RVALID && rd_addr_reg[ADDR_W-1:2] == '0
      |-> (S_AXI_RDATA & ~RCC_STATUS_MASK) == 32'h0) else $error("unused status bit set");
   unmapped_read_a: assert property (S_AXI_RVALID && rd_addr_reg[ADDR_W-1:2] > 4
      |-> S_AXI_RRESP == RCC_RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("unmapped read answered");
   cover property (SYSTEM_MASTER_RESET ##1 !SYSTEM_MASTER_RESET);
   cover property (S_AXI_RVALID && S_AXI_RRESP == RCC_RESP_SLVERR);
   cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule
bind rcc_top rcc_monitor #(.ADDR_W(ADDR_W), .RST_HOLD_CYC(RST_HOLD_CYC)) mon (.*);
`default_nettype wire

/* File: verif/rcc_src_model.sv */
// Purpose: Reset source detectors and wake logic feeding the collector.
// Assumes: Index 0 to 9: power-on, brown-out, pin, watchdog, deadman, mismatch,
//          primary read error, both read error, sleep wake, idle wake.
// Notes: Every line stays quiet except the one-cycle request asked for.
`timescale 1ns/1ps
`default_nettype none
module rcc_src_model (
   input wire logic clk,
   input wire logic [3:0] sel,
   input wire logic go,
   output logic [9:0] req = 10'h000
);
   always @(posedge clk) begin
      req <= go ? (10'h001 << sel) : 10'h000;
   end
endmodule
`default_nettype wire

/* File: verif/test_reset_cause_collector.sv */
// Purpose: Self-checking bench for the reset cause collector.
// Assumes: Hold count shortened to 2 cycles.
// Notes: A watcher checks read data and write answers from queues.
`timescale 1ns/1ps
`default_nettype none
module test_reset_cause_collector;
   import rcc_pkg::*;
   logic clk = 1'b0, nrst = 1'b0;
   logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
   logic [31:0] w_data = 32'h0;
   logic [3:0] w_strb = 4'h0, src_sel = 4'h0, stb;
   logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0, src_go = 1'b0;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid, smr, irq;
   logic [1:0] b_resp, r_resp;
   logic [31:0] r_data, st, rnd, lanes;
   logic [9:0] req;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int failures = 0, checks = 0, cycles = 0, seed = 79;
   int src_bit[10] = '{0, 1, 7, 4, 5, 9, 27, 26, 3, 2};
   always #4 clk = ~clk;
   rcc_top #(.RST_HOLD_CYC(2)) uut (
      .CLK(clk), .NRST(nrst), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
      .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
      .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
      .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
      .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .POWER_ON_REQUEST(req[0]), .BROWNOUT_REQUEST(req[1]),
      .MASTER_CLEAR_PIN_N(~req[2]), .WATCHDOG_RESET_REQUEST(req[3]), .DEADMAN_RESET_REQUEST(req[4]),
      .CONFIG_MISMATCH_REQUEST(req[5]), .PRIMARY_CONFIG_READ_ERROR(req[6]), .BOTH_CONFIG_READ_ERROR(req[7]),
      .SLEEP_WAKE(req[8]), .IDLE_WAKE(req[9]), .SYSTEM_MASTER_RESET(smr), .IRQ(irq));
   rcc_src_model src (.clk(clk), .sel(src_sel), .go(src_go), .req(req));
   task automatic chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Watcher: takes the oldest note whenever an answer is handed over
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         failures++;
         end_of_test();
      end
      if (r_valid && r_ready) chk("read", {r_resp, r_data}, rq.pop_front());
      if (b_valid && b_ready) chk("bresp", {32'h0, b_resp}, {32'h0, bq.pop_front()});
   end
   // ---------------------------------------------------------------
   // Bus and source tasks
   // ---------------------------------------------------------------
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do @(posedge clk); while (!ar_ready);
      ar_valid <= 1'b0;
      while (!r_valid) @(posedge clk);
      r_ready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      bq.push_back(e);
      aw_addr <= a;
      w_data <= d;
      w_strb <= s;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk);
         ad = ad | aw_ready;
         wd = wd | w_ready;
         if (ad) aw_valid <= 1'b0;
         if (wd) w_valid <= 1'b0;
      end
      while (!b_valid) @(posedge clk);
      b_ready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_smr(input logic lvl);
      int n;
      n = 0;
      while (smr !== lvl && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk("master reset", {33'h0, smr}, {33'h0, lvl});
   endtask
   task automatic pulse(input int i);
      src_sel <= i[3:0];
      src_go <= 1'b1;
      @(posedge clk);
      src_go <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(RCC_STATUS_OFF, {RCC_RESP_OKAY, RCC_STATUS_RST});
      rd(RCC_IRQ_EN_OFF, {RCC_RESP_OKAY, RCC_ZERO_RST});
      wait_smr(1'b0);
      wr(RCC_STATUS_OFF, 32'h0, 4'hf, RCC_RESP_OKAY);
      rd(RCC_STATUS_OFF, {RCC_RESP_OKAY, RCC_ZERO_RST});
      wr(RCC_IRQ_EN_OFF, RCC_STATUS_MASK, 4'hf, RCC_RESP_OKAY);
      for (int i = 0; i < 10; i++) begin
         pulse(i);
         if (i < 6) wait_smr(1'b1);
         wait_smr(1'b0);
         repeat (3) @(posedge clk);
         chk("irq raised", {33'h0, irq}, 34'h1);
         rd(RCC_STATUS_OFF, {RCC_RESP_OKAY, 32'h1 << src_bit[i]});
         rd(RCC_IRQ_STAT_OFF, {RCC_RESP_OKAY, 32'h1 << src_bit[i]});
         wr(RCC_STATUS_OFF, 32'h0, 4'hf, RCC_RESP_OKAY);
         wr(RCC_IRQ_CLR_OFF, RCC_STATUS_MASK, 4'hf, RCC_RESP_OKAY);
         repeat (3) @(posedge clk);
         chk("irq cleared", {33'h0, irq}, 34'h0);
      end
      wr(RCC_IRQ_EN_OFF, 32'h0, 4'hf, RCC_RESP_OKAY);
      pulse(9);
      repeat (3) @(posedge clk);
      chk("irq masked", {33'h0, irq}, 34'h0);
      wr(RCC_IRQ_EN_OFF, 32'h4, 4'hf, RCC_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("irq enabled", {33'h0, irq}, 34'h1);
      wr(RCC_IRQ_CLR_OFF, 32'h4, 4'hf, RCC_RESP_OKAY);
      rd(RCC_IRQ_STAT_OFF, {RCC_RESP_OKAY, RCC_ZERO_RST});
      chk("irq after clear", {33'h0, irq}, 34'h0);
      wr(RCC_SW_RST_OFF, 32'h1, 4'h1, RCC_RESP_OKAY);
      wait_smr(1'b1);
      wait_smr(1'b0);
      rd(RCC_STATUS_OFF, {RCC_RESP_OKAY, 32'h44});
      rd(RCC_SW_RST_OFF, {RCC_RESP_OKAY, RCC_ZERO_RST});
      rd(8'h20, {RCC_RESP_SLVERR, RCC_ZERO_RST});
      wr(8'h20, 32'hffffffff, 4'hf, RCC_RESP_SLVERR);
      st = 32'h0;
      wr(RCC_STATUS_OFF, st, 4'hf, RCC_RESP_OKAY);
      for (int k = 0; k < 4; k++) begin
         rnd = 32'($random(seed));
         stb = 4'($random(seed));
         lanes = {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}};
         st = ((st & ~lanes) | (rnd & lanes)) & RCC_STATUS_MASK;
         wr(RCC_STATUS_OFF, rnd, stb, RCC_RESP_OKAY);
         rd(RCC_STATUS_OFF, {RCC_RESP_OKAY, st});
      end
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(RCC_STATUS_OFF, {RCC_RESP_OKAY, RCC_STATUS_RST});
      wait_smr(1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
